// ### verilog/srs_defs.svh
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH
// status byte bit positions
`define SRS_STB_QUES      3
`define SRS_STB_MAV       4
`define SRS_STB_ESB       5
`define SRS_STB_RQS       6
`define SRS_STB_OPER      7
`define SRS_STB_RQS_CLR   8'hbf
// standard event bit positions
`define SRS_ESR_OPC       0
`define SRS_ESR_QUERY     2
`define SRS_ESR_DEVICE    3
`define SRS_ESR_EXEC      4
`define SRS_ESR_CMD       5
`define SRS_ESR_PON       7
`define SRS_ESR_MASK      8'hbd
// warning group bits that exist; all others read zero
`define SRS_QUES_MASK     16'h0227
// argument limits
`define SRS_MASK_MAX      16'h00ff
`define SRS_SLOT_SAVE_MIN 16'h0001
`define SRS_SLOT_MAX      16'h0004
// reset values, default setting and sizes
`define SRS_ADDR_DEFAULT  5'h0a
`define SRS_SET_DEFAULT   16'h0000
`define SRS_ESR_RESET     8'h80
`define SRS_SET_W         16
`define SRS_SLOTS         4
`endif

// ### verilog/srs_pkg.sv
`include "srs_defs.svh"
package srs_pkg;
  // common commands seen by the status block
  typedef enum logic [4:0] {
    SRS_CLS, SRS_ESE, SRS_ESE_Q, SRS_ESR_Q, SRS_OPC, SRS_OPC_Q, SRS_SRE, SRS_SRE_Q,
    SRS_STB_Q, SRS_WAI, SRS_RST, SRS_SAV, SRS_RCL, SRS_QCOND_Q, SRS_QEVENT_Q,
    SRS_QPTR, SRS_QPTR_Q, SRS_QNTR, SRS_QNTR_Q, SRS_OCOND_Q, SRS_OEVENT_Q
  } srs_op_t;

  typedef struct packed {
    srs_op_t     op;
    logic [15:0] arg;
  } srs_cmd_t;

  typedef struct packed {
    logic [15:0]                          qs1, qs2, qprev, ptr, ntr, qev;
    logic                                 ls1, ls2;
    logic [7:0]                           esr, ese, sre;
    logic                                 opc_armed, opc_q_wait, wai_hold;
    logic                                 remote, rqs;
    logic [4:0]                           addr;
    logic                                 rsp_valid;
    logic [15:0]                          rsp_data;
    logic                                 spoll_valid;
    logic [7:0]                           spoll_byte;
    logic [`SRS_SLOTS-1:0][`SRS_SET_W-1:0] slot;
    logic [`SRS_SET_W-1:0]                setting_out;
    logic                                 setting_load, settings_reset;
  } srs_state_t;
endpackage

// ### verilog/srs_status.sv
`timescale 1ns/1ps
// Functional notes
// R1 - warning condition bits follow live inputs, never latched, read only.
// R2 - per-bit rise and fall filters choose which condition change sets events.
// R3 - filter registers read/write and survive clear-status.
// R4 - event registers latch, clear on read and on clear-status, read only.
// R5 - a set event bit stays set; further transitions are not counted.
// R6 - summary bit is OR of event ANDed with enable.
// R7 - enable registers read/write, untouched by clear-status or reads.
// R8 - status byte bit 6 is request service; while set drive SRQ.
// R9 - status byte bits 0-2 zero; 3 warning, 4 message, 5 event, 7 unused.
// R10 - status byte answered by serial poll and by status-byte query.
// R11 - standard event bits 0,2,3,4,5,7 defined; bits 1 and 6 zero.
// R12 - unused operation group condition and event always read zero.
// R13 - warning bits 0,1,2,5,9 only; all others zero.
// R14 - warning raised when settings may jointly yield an invalid output.
// R15 - warning group: condition, filters, event; others event and enable only.
// R16 - service request mask 0-255 written and read back.
// R17 - event enable 0-255 written and read back; event register queryable.
// R18 - operation complete set after pending work; query reports; wait stalls.
// R19 - clear-status clears event registers only.
// R20 - first bus command enters remote and locks the front panel.
// R21 - bus address defaults to 10, set only from the front panel.
// R22 - settings saved to slots 1-4, recalled from 0-4.
// R23 - request service set when any enabled status byte bit is set.
`include "srs_defs.svh"
module srs_status (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // decoded common commands
  input  wire logic                  cmd_valid,
  input  wire srs_pkg::srs_cmd_t     cmd,
  output logic                       cmd_ready,
  // query answers
  output logic                       rsp_valid,
  output logic [15:0]                rsp_data,
  // serial poll
  input  wire logic                  spoll_req,
  output logic                       spoll_valid,
  output logic [7:0]                 spoll_byte,
  // warning conditions from the output stage, asynchronous
  input  wire logic [15:0]           warn_pin,
  // device events, same clock
  input  wire logic                  err_query,
  input  wire logic                  err_device,
  input  wire logic                  err_exec,
  input  wire logic                  err_command,
  input  wire logic                  msg_avail,
  input  wire logic                  busy,
  // front panel
  input  wire logic                  local_key,
  input  wire logic                  addr_wr,
  input  wire logic [4:0]            addr_data,
  output logic                       remote_lock,
  output logic [4:0]                 bus_addr,
  // service request line, open drain
  output logic                       srq_out,
  output logic                       srq_oe_n,
  // instrument setting store
  input  wire logic [`SRS_SET_W-1:0] setting_in,
  output logic [`SRS_SET_W-1:0]      setting_out,
  output logic                       setting_load,
  output logic                       settings_reset
);

  // ************************************************************
  // status byte assembly
  // ************************************************************

  // used for the status-byte query and the serial poll alike
  function automatic logic [7:0] srs_stb(input logic [15:0] qev, input logic [7:0] esr,
                                         input logic [7:0] ese, input logic [7:0] sre,
                                         input logic mav);
    logic [7:0] b;
    b = 8'h00;                                          // [R9]
    b[`SRS_STB_QUES] = |qev;                            // [R15]
    b[`SRS_STB_MAV]  = mav;                             // [R9]
    b[`SRS_STB_ESB]  = |(esr & ese);                    // [R6]
    b[`SRS_STB_RQS]  = |(b & sre & `SRS_STB_RQS_CLR);   // [R23]
    return b;
  endfunction

  srs_pkg::srs_state_t st;
  srs_pkg::srs_state_t next_st;
  wire logic [15:0]    qhit;
  logic                take;

  // ************************************************************
  // transition filters
  // ************************************************************

  // one detector per warning bit on the synchronised condition
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_filt
      assign qhit[gi] = (st.qs2[gi] & ~st.qprev[gi] & st.ptr[gi])    // [R2]
                      | (~st.qs2[gi] & st.qprev[gi] & st.ntr[gi]);   // [R2]
    end
  endgenerate

  // stall while a wait or a completion query is outstanding
  assign cmd_ready = ~st.wai_hold & ~st.opc_q_wait;   // [R18]
  assign take      = cmd_valid & cmd_ready;

  // ************************************************************
  // next state
  // ************************************************************

  always_comb begin
    logic [15:0] q_new;
    logic [7:0]  e_new;
    logic        q_clr;
    logic        e_clr;
    logic        arg_mask_ok;
    logic        arg_slot_ok;
    q_new       = 16'h0000;
    e_new       = 8'h00;
    q_clr       = 1'b0;
    e_clr       = 1'b0;
    arg_mask_ok = cmd.arg <= `SRS_MASK_MAX;
    arg_slot_ok = cmd.arg <= `SRS_SLOT_MAX;
    next_st = st;
    next_st.rsp_valid      = 1'b0;
    next_st.spoll_valid    = 1'b0;
    next_st.setting_load   = 1'b0;
    next_st.settings_reset = 1'b0;
    // two-flop synchronisers; first stage feeds only the second
    next_st.qs1   = warn_pin;
    next_st.qs2   = st.qs1;                             // [R1]
    next_st.qprev = st.qs2;
    next_st.ls1   = local_key;
    next_st.ls2   = st.ls1;
    // warnings: live condition through the filters, only real bits
    q_new = qhit & `SRS_QUES_MASK;                      // [R14] [R13]
    e_new[`SRS_ESR_QUERY]  = err_query;
    e_new[`SRS_ESR_DEVICE] = err_device;
    e_new[`SRS_ESR_EXEC]   = err_exec;
    e_new[`SRS_ESR_CMD]    = err_command;
    // operation complete once pending work drains
    if (st.opc_armed && !busy) begin
      e_new[`SRS_ESR_OPC] = 1'b1;                       // [R18]
      next_st.opc_armed   = 1'b0;
    end
    if (st.opc_q_wait && !busy) begin
      next_st.opc_q_wait = 1'b0;
      next_st.rsp_valid  = 1'b1;                        // [R18]
      next_st.rsp_data   = 16'h0001;
    end
    if (st.wai_hold && !busy) begin
      next_st.wai_hold = 1'b0;                          // [R18]
    end
    // serial poll snapshot of the live status byte
    if (spoll_req) begin
      next_st.spoll_valid = 1'b1;
      next_st.spoll_byte  = srs_stb(st.qev, st.esr, st.ese, st.sre, msg_avail);   // [R10]
    end
    if (take) begin
      next_st.remote = 1'b1;                            // [R20]
      case (cmd.op)
        srs_pkg::SRS_CLS: begin
          q_clr = 1'b1;                                 // [R19] [R4]
          e_clr = 1'b1;                                 // [R19]
        end
        srs_pkg::SRS_ESE: begin
          if (arg_mask_ok) next_st.ese = cmd.arg[7:0];  // [R17] [R7]
          else e_new[`SRS_ESR_EXEC] = 1'b1;
        end
        srs_pkg::SRS_SRE: begin
          if (arg_mask_ok) next_st.sre = cmd.arg[7:0];  // [R16] [R7]
          else e_new[`SRS_ESR_EXEC] = 1'b1;
        end
        srs_pkg::SRS_ESE_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = {8'h00, st.ese};          // [R17]
        end
        srs_pkg::SRS_SRE_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = {8'h00, st.sre};          // [R16]
        end
        srs_pkg::SRS_ESR_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = {8'h00, st.esr};          // [R17]
          e_clr = 1'b1;                                 // [R4]
        end
        srs_pkg::SRS_STB_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = {8'h00, srs_stb(st.qev, st.esr, st.ese, st.sre, msg_avail)};  // [R10]
        end
        srs_pkg::SRS_OPC:   next_st.opc_armed  = 1'b1;  // [R18]
        srs_pkg::SRS_OPC_Q: next_st.opc_q_wait = 1'b1;  // [R18]
        srs_pkg::SRS_WAI:   next_st.wai_hold   = 1'b1;  // [R18]
        srs_pkg::SRS_RST:   next_st.settings_reset = 1'b1;
        srs_pkg::SRS_SAV: begin
          if (arg_slot_ok && cmd.arg >= `SRS_SLOT_SAVE_MIN)
            next_st.slot[cmd.arg[1:0] - 2'd1] = setting_in;   // [R22]
          else e_new[`SRS_ESR_EXEC] = 1'b1;
        end
        srs_pkg::SRS_RCL: begin
          if (arg_slot_ok) begin
            next_st.setting_load = 1'b1;                // [R22]
            next_st.setting_out  = (cmd.arg == 16'h0000) ? `SRS_SET_DEFAULT
                                 : st.slot[cmd.arg[1:0] - 2'd1];
          end else e_new[`SRS_ESR_EXEC] = 1'b1;
        end
        srs_pkg::SRS_QCOND_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.qs2 & `SRS_QUES_MASK;  // [R1]
        end
        srs_pkg::SRS_QEVENT_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.qev;
          q_clr = 1'b1;                                 // [R4]
        end
        srs_pkg::SRS_QPTR:   next_st.ptr = cmd.arg & `SRS_QUES_MASK;   // [R3]
        srs_pkg::SRS_QNTR:   next_st.ntr = cmd.arg & `SRS_QUES_MASK;   // [R3]
        srs_pkg::SRS_QPTR_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.ptr;                   // [R3]
        end
        srs_pkg::SRS_QNTR_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.ntr;                   // [R3]
        end
        srs_pkg::SRS_OCOND_Q, srs_pkg::SRS_OEVENT_Q: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = 16'h0000;                 // [R12]
        end
        default: e_new[`SRS_ESR_CMD] = 1'b1;
      endcase
    end else if (st.ls2) begin
      next_st.remote = 1'b0;                            // local key returns control
    end
    // address only from the front panel, never from the bus
    if (addr_wr && !st.remote) next_st.addr = addr_data;   // [R21]
    // new events win over a clear in the same cycle; set bits just stay set
    next_st.qev = ((q_clr ? 16'h0000 : st.qev) | q_new) & `SRS_QUES_MASK;   // [R5] [R15]
    next_st.esr = ((e_clr ? 8'h00 : st.esr) | e_new) & `SRS_ESR_MASK;       // [R5] [R11]
    next_st.rqs = srs_stb(st.qev, st.esr, st.ese, st.sre, msg_avail)
                  >> `SRS_STB_RQS != 8'h00;             // [R23]
  end

  // ************************************************************
  // state register
  // ************************************************************

  // power-on leaves only the power-on event set
  always_ff @(posedge clk) begin
    if (reset) begin
      st      <= '0;
      st.addr <= `SRS_ADDR_DEFAULT;                     // [R21]
      st.esr  <= `SRS_ESR_RESET;                        // [R11]
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops; srq_out tied low
  assign rsp_valid      = st.rsp_valid;
  assign rsp_data       = st.rsp_data;
  assign spoll_valid    = st.spoll_valid;
  assign spoll_byte     = st.spoll_byte;
  assign remote_lock    = st.remote;                    // [R20]
  assign bus_addr       = st.addr;
  assign srq_out        = 1'b0;
  assign srq_oe_n       = ~st.rqs;                      // [R8]
  assign setting_out    = st.setting_out;
  assign setting_load   = st.setting_load;
  assign settings_reset = st.settings_reset;

  // ************************************************************
  // checks
  // ************************************************************

  chk_rise_sets_event: assert property (@(posedge clk) disable iff (reset)  // [R2]
    (st.qs2[0] && !st.qprev[0] && st.ptr[0]) |=> st.qev[0])
    else $error("rising warning did not set its event bit");

  chk_cls_keeps_masks: assert property (@(posedge clk) disable iff (reset)  // [R7]
    (take && cmd.op == srs_pkg::SRS_CLS) |=>
      $stable(st.ptr) && $stable(st.ntr) && $stable(st.ese) && $stable(st.sre))
    else $error("clear-status touched a filter or enable");

  chk_read_clears: assert property (@(posedge clk) disable iff (reset)  // [R4]
    (take && cmd.op == srs_pkg::SRS_QEVENT_Q && qhit == 16'h0000) |=>
      st.qev == 16'h0000 && rsp_valid)
    else $error("warning event not cleared by its read");

  chk_event_sticky: assert property (@(posedge clk) disable iff (reset)  // [R5]
    (st.esr[`SRS_ESR_CMD] && !(take && (cmd.op == srs_pkg::SRS_CLS
      || cmd.op == srs_pkg::SRS_ESR_Q))) |=> st.esr[`SRS_ESR_CMD])
    else $error("event bit dropped without a clear");

  chk_unused_zero: assert property (@(posedge clk) disable iff (reset)  // [R13]
    (st.esr & ~`SRS_ESR_MASK) == 8'h00 && (st.qev & ~`SRS_QUES_MASK) == 16'h0000)
    else $error("unused status bit reads one");

  chk_opc_done: assert property (@(posedge clk) disable iff (reset)  // [R18]
    (st.opc_armed && !busy) |=> st.esr[`SRS_ESR_OPC] && !st.opc_armed)
    else $error("operation complete not recorded");

  chk_remote_entry: assert property (@(posedge clk) disable iff (reset)  // [R20]
    take |=> remote_lock)
    else $error("command did not enter remote");

  chk_addr_local: assert property (@(posedge clk) disable iff (reset)  // [R21]
    !addr_wr |=> $stable(bus_addr))
    else $error("bus address changed without front panel write");

  chk_sre_zero_quiet: assert property (@(posedge clk) disable iff (reset)  // [R23]
    (take && cmd.op == srs_pkg::SRS_SRE && cmd.arg == 16'h0000) |-> ##2 srq_oe_n)
    else $error("service request with empty mask");

  // answers, summaries, stalls, events, address and settings; each watches one rule

  chk_fall_sets_event: assert property (@(posedge clk) disable iff (reset)  // [R2]
    (!st.qs2[9] && st.qprev[9] && st.ntr[9]) |=> st.qev[9])
    else $error("falling warning did not set its event bit");

  chk_cond_live: assert property (@(posedge clk) disable iff (reset)  // [R1]
    (take && cmd.op == srs_pkg::SRS_QCOND_Q) |=>
      rsp_valid && rsp_data == ($past(st.qs2) & `SRS_QUES_MASK))
    else $error("condition answer not the live warning state");

  chk_filter_readback: assert property (@(posedge clk) disable iff (reset)  // [R3]
    (take && cmd.op == srs_pkg::SRS_QNTR_Q) |=> rsp_valid && rsp_data == st.ntr)
    else $error("fall filter read back wrong");

  chk_spoll_answer: assert property (@(posedge clk) disable iff (reset)  // [R10]
    spoll_req |=> spoll_valid)
    else $error("serial poll not answered");

  chk_stb_zero_bits: assert property (@(posedge clk) disable iff (reset)  // [R9]
    spoll_valid |-> spoll_byte[2:0] == 3'b000 && !spoll_byte[`SRS_STB_OPER])
    else $error("unused status byte bit set");

  chk_esb_summary: assert property (@(posedge clk) disable iff (reset)  // [R6]
    (spoll_req && (st.esr & st.ese) != 8'h00) |=> spoll_byte[`SRS_STB_ESB])
    else $error("event summary missing from status byte");

  chk_rqs_drives_srq: assert property (@(posedge clk) disable iff (reset)  // [R8]
    ((st.esr & st.ese) != 8'h00 && st.sre[`SRS_STB_ESB]) |=> !srq_oe_n)
    else $error("service request line not pulled");

  chk_enable_by_write: assert property (@(posedge clk) disable iff (reset)  // [R7]
    !(take && cmd.op == srs_pkg::SRS_ESE) |=> $stable(st.ese))
    else $error("event enable changed without a write");

  chk_wai_release: assert property (@(posedge clk) disable iff (reset)  // [R18]
    (st.wai_hold && !busy) |=> cmd_ready)
    else $error("wait not released after pending work");

  chk_opc_query_answer: assert property (@(posedge clk) disable iff (reset)  // [R18]
    (st.opc_q_wait && !busy) |=> rsp_valid && rsp_data == 16'h0001)
    else $error("completion query not answered");

  chk_cls_clears: assert property (@(posedge clk) disable iff (reset)  // [R19]
    (take && cmd.op == srs_pkg::SRS_CLS && qhit == 16'h0000) |=> st.qev == 16'h0000)
    else $error("clear-status left a warning event");

  chk_addr_remote: assert property (@(posedge clk) disable iff (reset)  // [R21]
    st.remote |=> $stable(bus_addr))
    else $error("bus address changed while remote");

  chk_recall_pulse: assert property (@(posedge clk) disable iff (reset)  // [R22]
    (take && cmd.op == srs_pkg::SRS_RCL && cmd.arg <= `SRS_SLOT_MAX) |=> setting_load)
    else $error("recall did not load a setting");

  chk_save_slot: assert property (@(posedge clk) disable iff (reset)  // [R22]
    (take && cmd.op == srs_pkg::SRS_SAV && cmd.arg == 16'h0002) |=>
      st.slot[1] == $past(setting_in))
    else $error("save did not store the setting");

  chk_oper_zero: assert property (@(posedge clk) disable iff (reset)  // [R12]
    (take && (cmd.op == srs_pkg::SRS_OCOND_Q || cmd.op == srs_pkg::SRS_OEVENT_Q)) |=>
      rsp_valid && rsp_data == 16'h0000)
    else $error("unused operation group read nonzero");

endmodule

// ### tb/srs_ctrl_model.sv
`timescale 1ns/1ps
// ****************************************
// bus controller issuing common commands
// ****************************************
module srs_ctrl_model (
  // clock
  input  wire logic          clk,
  // command port toward the status block
  output srs_pkg::srs_cmd_t  cmd,
  output logic               cmd_valid,
  input  wire logic          cmd_ready
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // hold the request until ready is seen at a falling edge, then drop it after the next rising edge
  // and scramble the argument so stale data never looks valid
  task automatic send(input srs_pkg::srs_op_t op, input logic [15:0] arg);
    @(posedge clk);
    #2;
    cmd_valid = 1'b1;
    cmd       = '{op, arg};
    #48;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #50;
    end
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    cmd.arg   = ~arg;
  endtask
endmodule

// ### tb/test_status_reporting_488.sv
`timescale 1ns/1ps
module test_status_reporting_488;
  logic clk, reset, spoll_req, msg_avail, busy, local_key, addr_wr;
  logic [3:0] err;
  logic [4:0] addr_data;
  logic [15:0] warn_pin, setting_in, r1, r2, sv;
  logic rsp_valid, spoll_valid, remote_lock, srq_out, srq_oe_n, setting_load, settings_reset;
  logic cmd_valid, cmd_ready;
  logic [15:0] rsp_data, setting_out;
  logic [7:0] spoll_byte;
  logic [4:0] bus_addr;
  srs_pkg::srs_cmd_t cmd;
  logic [15:0] exp_q[$];
  int bad_count, num_checks;

  srs_ctrl_model ctl_u (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));
  srs_status dut_u (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .spoll_req(spoll_req), .spoll_valid(spoll_valid), .spoll_byte(spoll_byte),
    .warn_pin(warn_pin), .err_query(err[0]), .err_device(err[1]), .err_exec(err[2]),
    .err_command(err[3]), .msg_avail(msg_avail), .busy(busy), .local_key(local_key),
    .addr_wr(addr_wr), .addr_data(addr_data), .remote_lock(remote_lock),
    .bus_addr(bus_addr), .srq_out(srq_out), .srq_oe_n(srq_oe_n),
    .setting_in(setting_in), .setting_out(setting_out), .setting_load(setting_load),
    .settings_reset(settings_reset));

  // ****************************************
  // clock, compare and closing tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // note the expected answer, then issue the query
  task automatic query(input srs_pkg::srs_op_t op, input logic [15:0] e);
    exp_q.push_back(e);
    ctl_u.send(op, 16'h0000);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // ****************************************
  // answer monitor: oldest note against each answer
  // ****************************************
  always @(posedge clk) begin
    #1;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected answer", 16'hffff, rsp_data);
      end else begin
        chk("rsp_data", exp_q.pop_front(), rsp_data);
      end
    end
  end

  // watchdog sized well above the sequence length
  initial begin
    #3_000_000;
    bad_count++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reset, spoll_req, msg_avail, busy, local_key, addr_wr, err} = '0;
    {addr_data, warn_pin, setting_in} = '0;
    reset = 1'b1;
    void'($urandom(39));
    cyc(5);
    reset = 1'b0;
    chk("remote_lock reset", 16'h0, remote_lock);
    chk("srq_oe_n reset", 16'h1, srq_oe_n);
    // power-on event, then clear on read
    query(srs_pkg::SRS_ESR_Q, 16'h0080);
    query(srs_pkg::SRS_ESR_Q, 16'h0000);
    chk("remote_lock", 16'h1, remote_lock);
    chk("bus_addr", 16'h000a, bus_addr);
    $display("test reset_events done");
    // masks survive clear-status and reads
    r1 = 16'($urandom_range(255));
    r2 = 16'($urandom_range(255));
    ctl_u.send(srs_pkg::SRS_SRE, r1);
    ctl_u.send(srs_pkg::SRS_ESE, r2);
    ctl_u.send(srs_pkg::SRS_CLS, 16'h0000);
    query(srs_pkg::SRS_SRE_Q, r1);
    query(srs_pkg::SRS_ESE_Q, r2);
    ctl_u.send(srs_pkg::SRS_ESE, 16'h0100);
    query(srs_pkg::SRS_ESR_Q, 16'h0010);
    query(srs_pkg::SRS_ESE_Q, r2);
    ctl_u.send(srs_pkg::srs_op_t'(5'd31), 16'h0000);
    query(srs_pkg::SRS_ESR_Q, 16'h0020);
    $display("test masks done");
    // each device error lands on its own event bit
    for (int i = 0; i < 4; i++) begin
      err[i] = 1'b1;
      cyc(1);
      err[i] = 1'b0;
      query(srs_pkg::SRS_ESR_Q, 16'h0004 << i);
    end
    $display("test errors done");
    // summary, request service, serial poll
    ctl_u.send(srs_pkg::SRS_CLS, 16'h0000);
    ctl_u.send(srs_pkg::SRS_SRE, 16'h0020);
    ctl_u.send(srs_pkg::SRS_ESE, 16'h0020);
    msg_avail = 1'b1;
    cyc(4);
    chk("srq_oe_n idle", 16'h1, srq_oe_n);
    err[3] = 1'b1;
    cyc(1);
    err[3] = 1'b0;
    cyc(4);
    chk("srq_oe_n", 16'h0, srq_oe_n);
    query(srs_pkg::SRS_STB_Q, 16'h0070);
    cyc(1);
    spoll_req = 1'b1;
    @(posedge clk);
    #1;
    chk("spoll_valid", 16'h1, spoll_valid);
    chk("spoll_byte", 16'h0070, spoll_byte);
    #1;
    spoll_req = 1'b0;
    query(srs_pkg::SRS_ESR_Q, 16'h0020);
    msg_avail = 1'b0;
    cyc(4);
    chk("srq_oe_n released", 16'h1, srq_oe_n);
    chk("srq_out", 16'h0, srq_out);
    err[3] = 1'b1;
    cyc(1);
    err[3] = 1'b0;
    cyc(4);
    chk("srq_oe_n again", 16'h0, srq_oe_n);
    ctl_u.send(srs_pkg::SRS_SRE, 16'h0000);
    cyc(2);
    chk("srq_oe_n masked", 16'h1, srq_oe_n);
    query(srs_pkg::SRS_ESR_Q, 16'h0020);
    $display("test status_byte done");
    // warning group filters and events
    ctl_u.send(srs_pkg::SRS_QPTR, 16'h0001);
    ctl_u.send(srs_pkg::SRS_QNTR, 16'h0200);
    warn_pin = 16'h0209;
    cyc(6);
    query(srs_pkg::SRS_QCOND_Q, 16'h0201);
    query(srs_pkg::SRS_QEVENT_Q, 16'h0001);
    warn_pin = 16'h0000;
    cyc(6);
    query(srs_pkg::SRS_QCOND_Q, 16'h0000);
    query(srs_pkg::SRS_QEVENT_Q, 16'h0200);
    ctl_u.send(srs_pkg::SRS_CLS, 16'h0000);
    query(srs_pkg::SRS_QPTR_Q, 16'h0001);
    query(srs_pkg::SRS_QNTR_Q, 16'h0200);
    query(srs_pkg::SRS_OCOND_Q, 16'h0000);
    query(srs_pkg::SRS_OEVENT_Q, 16'h0000);
    $display("test warnings done");
    // operation complete with and without pending work
    ctl_u.send(srs_pkg::SRS_OPC, 16'h0000);
    cyc(3);
    query(srs_pkg::SRS_ESR_Q, 16'h0001);
    busy = 1'b1;
    query(srs_pkg::SRS_OPC_Q, 16'h0001);
    cyc(10);
    chk("opc query early", 16'h1, 16'(exp_q.size()));
    busy = 1'b0;
    cyc(4);
    chk("opc query answered", 16'h0, 16'(exp_q.size()));
    busy = 1'b1;
    ctl_u.send(srs_pkg::SRS_WAI, 16'h0000);
    chk("cmd_ready wait", 16'h0, cmd_ready);
    busy = 1'b0;
    cyc(2);
    chk("cmd_ready resumed", 16'h1, cmd_ready);
    $display("test completion done");
    // save and recall, slot 0 holds the default
    sv = 16'($urandom());
    setting_in = sv;
    ctl_u.send(srs_pkg::SRS_SAV, 16'h0002);
    setting_in = ~sv;
    ctl_u.send(srs_pkg::SRS_RCL, 16'h0002);
    chk("setting_load", 16'h1, setting_load);
    cyc(3);
    chk("setting_out", sv, setting_out);
    ctl_u.send(srs_pkg::SRS_RCL, 16'h0000);
    cyc(3);
    chk("setting_out slot0", 16'h0000, setting_out);
    ctl_u.send(srs_pkg::SRS_SAV, 16'h0000);
    query(srs_pkg::SRS_ESR_Q, 16'h0010);
    ctl_u.send(srs_pkg::SRS_RST, 16'h0000);
    chk("settings_reset", 16'h1, settings_reset);
    $display("test settings done");
    // address locked while remote, settable once local
    addr_data = 5'h03;
    addr_wr = 1'b1;
    cyc(1);
    addr_wr = 1'b0;
    cyc(2);
    chk("bus_addr remote", 16'h000a, bus_addr);
    local_key = 1'b1;
    cyc(4);
    local_key = 1'b0;
    chk("remote_lock local", 16'h0, remote_lock);
    addr_wr = 1'b1;
    cyc(1);
    addr_wr = 1'b0;
    cyc(2);
    chk("bus_addr local", 16'h0003, bus_addr);
    $display("test remote done");
    test_done();
  end
endmodule
